// *** pag_gen.sv ***
// Program address generation and four-stage pipeline control
`timescale 1ns/10ps
`default_nettype none
module pag_gen (
    input  wire logic                       core_clk_in,
    input  wire logic                       resetn_in,
    input  wire logic [15:0]                program_read_path_in,
    input  wire logic [15:0]                data_read_path_in,
    input  wire pag_pkg::pag_op_t           exec_op_in,
    input  wire logic                       fetch_wait_in,
    input  wire logic [pag_pkg::IRQ_W-1:0]  irq_num_in,
    input  wire logic                       aux_dec_we_in,
    input  wire logic [pag_pkg::ARP_W-1:0]  aux_dec_val_in,
    input  wire logic [pag_pkg::ARP_W-1:0]  aux_normalize_op_val_in,
    output logic      [15:0]                program_address_bus_out,
    output logic      [15:0]                next_fetch_pointer_out,
    output logic      [15:0]                decode_word_out,
    output logic                            decode_valid_out,
    output logic      [15:0]                exec_word_out,
    output logic      [15:0]                exec_addr_out,
    output logic                            exec_valid_out,
    output logic      [15:0]                stack_top_out,
    output logic      [15:0]                repeat_count_out,
    output logic      [pag_pkg::WIN_W-1:0]  global_window_size_out,
    output logic      [pag_pkg::ARP_W-1:0]  aux_pointer_select_out,
    output pag_pkg::pag_state_t             pipe_state_out
);
    import pag_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] pag_inc(input logic [15:0] a);
        pag_inc = a + PC_STEP;
    endfunction : pag_inc

    function automatic logic pag_is_xfer(input pag_op_t op);
        pag_is_xfer = (op == PAG_OP_BRANCH) || (op == PAG_OP_CALL)
            || (op == PAG_OP_RETURN) || (op == PAG_OP_JUMP_TO_ACC)
            || (op == PAG_OP_CALL_TO_ACC) || (op == PAG_OP_INTERRUPT);
    endfunction : pag_is_xfer

    // ************************************************************
    // State
    // ************************************************************
    logic [15:0]      fetch_address_latch;
    logic [15:0]      next_fetch_pointer;
    logic [15:0]      micro_return_slot;
    logic [15:0]      repeat_count_reg;
    logic             rpt_pending;
    logic [15:0]      dec_word;
    logic [15:0]      dec_addr;
    logic             dec_valid;
    logic [15:0]      opn_word;
    logic [15:0]      opn_addr;
    logic             opn_valid;
    logic [15:0]      exe_word;
    logic [15:0]      exe_addr;
    logic             exe_valid;
    logic [WIN_W-1:0] global_window_size;
    logic [ARP_W-1:0] aux_pointer_select;
    logic [15:0]      stack_top;
    pag_state_t       state;

    logic             act;
    logic             taken;
    logic             start_rep;
    logic             rep_done;
    logic             move_done;
    logic             advance;
    logic             push;
    logic             pop;
    logic [15:0]      target;
    logic [15:0]      push_data;
    logic [15:0]      irq_vector;

    // ************************************************************
    // Control decode
    // ************************************************************
    assign act       = exe_valid && !fetch_wait_in && (state != PAG_ST_MOVE);
    assign taken     = act && (state == PAG_ST_RUN) && pag_is_xfer(exec_op_in);
    assign start_rep = act && (state == PAG_ST_RUN)
        && ((exec_op_in == PAG_OP_TWO_OPERAND)
            || (rpt_pending && exec_op_in != PAG_OP_REPEAT_LOAD
                && repeat_count_reg != COUNT_END));
    assign rep_done  = (state == PAG_ST_REPEAT) && !fetch_wait_in
        && (repeat_count_reg == COUNT_END);
    assign move_done = (state == PAG_ST_MOVE) && !fetch_wait_in
        && (repeat_count_reg == COUNT_END);
    assign advance   = !fetch_wait_in && !taken
        && (((state == PAG_ST_RUN) && !start_rep) || rep_done);
    assign irq_vector = ADDR_W'(irq_num_in) << VEC_SH;

    assign push = act && ((exec_op_in == PAG_OP_CALL)
        || (exec_op_in == PAG_OP_CALL_TO_ACC) || (exec_op_in == PAG_OP_INTERRUPT)
        || (exec_op_in == PAG_OP_PUSH_ACC) || (exec_op_in == PAG_OP_PUSH_DATA));
    assign pop  = act && ((exec_op_in == PAG_OP_RETURN)
        || (exec_op_in == PAG_OP_POP_ACC) || (exec_op_in == PAG_OP_POP_DATA));

    always_comb begin
        target    = next_fetch_pointer;
        push_data = data_read_path_in;
        case (exec_op_in)
            PAG_OP_BRANCH: target = opn_word;
            PAG_OP_CALL: begin
                target    = opn_word;
                push_data = pag_inc(opn_addr);
            end
            PAG_OP_RETURN: target = stack_top;
            PAG_OP_JUMP_TO_ACC: target = data_read_path_in;
            PAG_OP_CALL_TO_ACC: begin
                target    = data_read_path_in;
                push_data = pag_inc(exe_addr);
            end
            PAG_OP_INTERRUPT: begin
                target    = irq_vector;
                push_data = exe_addr;
            end
            default: target = next_fetch_pointer;
        endcase
    end

    // ************************************************************
    // Return stack
    // ************************************************************
    // eight by sixteen stack
    // data memory word via data path
    pag_stack #(
        .WIDTH (ADDR_W),
        .DEPTH (STACK_DEPTH)
    ) u_stack (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .push_in     (push),
        .pop_in      (pop),
        .data_in     (push_data),
        .top_out     (stack_top)
    );

    // ************************************************************
    // Fetch address and pointer
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            fetch_address_latch <= RESET_VEC;
            next_fetch_pointer  <= RESET_VEC + PC_STEP;
        end else if (taken) begin
            fetch_address_latch <= target;
            next_fetch_pointer  <= pag_inc(target);
        end else if (start_rep && exec_op_in == PAG_OP_TWO_OPERAND) begin
            fetch_address_latch <= opn_word;
            next_fetch_pointer  <= pag_inc(opn_word);
        end else if (move_done) begin
            fetch_address_latch <= micro_return_slot;
            next_fetch_pointer  <= pag_inc(micro_return_slot);
        end else if (advance || (state == PAG_ST_MOVE && !fetch_wait_in)) begin
            fetch_address_latch <= next_fetch_pointer;
            next_fetch_pointer  <= pag_inc(next_fetch_pointer);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            micro_return_slot <= RESET_VEC;
        end else if (start_rep && exec_op_in == PAG_OP_TWO_OPERAND) begin
            micro_return_slot <= fetch_address_latch;
        end
    end

    // ************************************************************
    // Pipeline stages
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            dec_valid <= 1'b0;
            opn_valid <= 1'b0;
            exe_valid <= 1'b0;
            dec_word  <= RESET_VEC;
            dec_addr  <= RESET_VEC;
            opn_word  <= RESET_VEC;
            opn_addr  <= RESET_VEC;
            exe_word  <= RESET_VEC;
            exe_addr  <= RESET_VEC;
        end else if (taken) begin
            dec_valid <= 1'b0;
            opn_valid <= 1'b0;
            exe_valid <= 1'b0;
        end else if (move_done) begin
            // The operand-address word is spent, so it never executes
            exe_valid <= 1'b0;
            opn_word  <= dec_word;
            opn_addr  <= dec_addr;
            opn_valid <= dec_valid;
            dec_valid <= 1'b0;
        end else if (advance) begin
            dec_word  <= program_read_path_in;
            dec_addr  <= fetch_address_latch;
            dec_valid <= 1'b1;
            opn_word  <= dec_word;
            opn_addr  <= dec_addr;
            opn_valid <= dec_valid;
            exe_word  <= opn_word;
            exe_addr  <= opn_addr;
            exe_valid <= opn_valid;
        end
    end

    // ************************************************************
    // Repeat sequencing
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state <= PAG_ST_RUN;
        end else begin
            unique case (state)
                PAG_ST_RUN: begin
                    if (start_rep && exec_op_in == PAG_OP_TWO_OPERAND) begin
                        state <= PAG_ST_MOVE;
                    end else if (start_rep) begin
                        state <= PAG_ST_REPEAT;
                    end
                end
                PAG_ST_REPEAT: begin
                    if (rep_done) begin
                        state <= PAG_ST_RUN;
                    end
                end
                PAG_ST_MOVE: begin
                    if (move_done) begin
                        state <= PAG_ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            repeat_count_reg <= COUNT_END;
            rpt_pending      <= 1'b0;
        end else if (act && state == PAG_ST_RUN
                     && exec_op_in == PAG_OP_REPEAT_LOAD) begin
            repeat_count_reg <= data_read_path_in;
            rpt_pending      <= 1'b1;
        end else begin
            if (advance || start_rep) begin
                rpt_pending <= 1'b0;
            end
            // first pass counts, so N gives N+1 passes
            if ((state != PAG_ST_RUN
                 || (start_rep && exec_op_in != PAG_OP_TWO_OPERAND))
                && !fetch_wait_in && repeat_count_reg != COUNT_END) begin
                repeat_count_reg <= repeat_count_reg - COUNT_ONE;
            end
        end
    end

    // ************************************************************
    // Window and auxiliary pointer
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            global_window_size <= WIN_RESET;
        end else if (act && exec_op_in == PAG_OP_WINDOW_WRITE) begin
            // written in execute, so decode still sees the old map
            global_window_size <= data_read_path_in[WIN_W-1:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            aux_pointer_select <= ARP_RESET;
        end else if (act && exec_op_in == PAG_OP_NORMALIZE) begin
            // no interlock, execute update lands last
            aux_pointer_select <= aux_normalize_op_val_in;
        end else if (aux_dec_we_in && advance) begin
            aux_pointer_select <= aux_dec_val_in;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // latch drives the bus
    assign program_address_bus_out = fetch_address_latch;
    assign next_fetch_pointer_out  = next_fetch_pointer;
    assign decode_word_out         = dec_word;
    assign decode_valid_out        = dec_valid;
    assign exec_word_out           = exe_word;
    assign exec_addr_out           = exe_addr;
    assign exec_valid_out          = exe_valid;
    assign stack_top_out           = stack_top;
    assign repeat_count_out        = repeat_count_reg;
    assign global_window_size_out  = global_window_size;
    assign aux_pointer_select_out  = aux_pointer_select;
    assign pipe_state_out          = state;

    // ************************************************************
    // Checks
    // ************************************************************
    a_reset_fetch: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        $rose(resetn_in) |-> fetch_address_latch == RESET_VEC)
        else $error("fetch did not start at reset vector");
    a_pointer_ahead: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        next_fetch_pointer == pag_inc(fetch_address_latch))
        else $error("pointer not one past fetch address");
    a_seq_step: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (advance && state == PAG_ST_RUN) |=> fetch_address_latch == $past(next_fetch_pointer))
        else $error("sequential fetch did not step");
    a_branch_target: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (taken && exec_op_in == PAG_OP_BRANCH) |=> fetch_address_latch == $past(opn_word))
        else $error("branch did not load immediate word");
    a_return_pop: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (taken && exec_op_in == PAG_OP_RETURN) |=> fetch_address_latch == $past(stack_top))
        else $error("return did not use stack top");
    a_acc_target: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (taken && exec_op_in == PAG_OP_JUMP_TO_ACC)
            |=> fetch_address_latch == $past(data_read_path_in))
        else $error("accumulator jump target wrong");
    a_dummy_hold: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fetch_wait_in |=> $stable(fetch_address_latch) && $stable(exe_word))
        else $error("dummy cycle moved the fetch address");
    a_call_push: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (taken && exec_op_in == PAG_OP_CALL) |=> stack_top == pag_inc($past(opn_addr)))
        else $error("call return address not pushed in time");
    a_flush_two: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        taken |=> !exe_valid ##1 !exe_valid ##1 !exe_valid)
        else $error("fetched words not discarded");
    a_move_return: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        move_done |=> fetch_address_latch == $past(micro_return_slot) && state == PAG_ST_RUN)
        else $error("move did not resume from slot");

endmodule : pag_gen
`default_nettype wire

// *** pag_gen_bench.sv ***
// Self-checking bench for the program address generator
`timescale 1ns/10ps
`default_nettype none
module pag_gen_bench;
    import pag_pkg::*;
    localparam logic [15:0] OFS = 16'h0040;
    logic core_clk_in, resetn_in, fetch_wait_in, aux_dec_we_in;
    logic [15:0] prog, data_read_path_in, bus, ptr, dword, xword, xaddr, top, cnt, e;
    logic [4:0] irq_num_in;
    logic [2:0] aux_dec_val_in, aux_normalize_op_val_in, aux;
    logic [7:0] win;
    logic dvalid, exec_valid_out;
    pag_op_t exec_op_in;
    pag_state_t st;
    int n_mismatch = 0;
    int checked = 0;
    pag_prog_mem #(.OFS(OFS)) i_mem (.addr_in(bus), .data_out(prog));
    pag_gen i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .program_read_path_in(prog), .data_read_path_in(data_read_path_in),
        .exec_op_in(exec_op_in), .fetch_wait_in(fetch_wait_in), .irq_num_in(irq_num_in),
        .aux_dec_we_in(aux_dec_we_in), .aux_dec_val_in(aux_dec_val_in),
        .aux_normalize_op_val_in(aux_normalize_op_val_in), .program_address_bus_out(bus),
        .next_fetch_pointer_out(ptr), .decode_word_out(dword), .decode_valid_out(dvalid),
        .exec_word_out(xword), .exec_addr_out(xaddr), .exec_valid_out(exec_valid_out),
        .stack_top_out(top), .repeat_count_out(cnt), .global_window_size_out(win),
        .aux_pointer_select_out(aux), .pipe_state_out(st));
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Waits for a word in execute, presents op at the next edge; caller clears it
    task automatic xfer(input pag_op_t op, input logic [15:0] d, output logic [15:0] a);
        int n;
        n = 0;
        while (exec_valid_out !== 1'b1 && n < 40) begin
            exec_op_in = PAG_OP_NONE;
            @(negedge core_clk_in);
            n++;
        end
        chk({15'h0000, exec_valid_out}, 16'h0001);
        a = xaddr;
        exec_op_in = op;
        data_read_path_in = d;
        @(negedge core_clk_in);
    endtask : xfer
    task automatic end_sim();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    task automatic t_reset_seq();
        logic [15:0] p;
        chk(bus, 16'h0000);
        chk(ptr, 16'h0001);
        chk({15'h0000, exec_valid_out | dvalid}, 16'h0000);
        chk({8'h00, win}, 16'h0000);
        chk(16'(st), 16'(PAG_ST_RUN));
        resetn_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        chk(xaddr, 16'h0000);
        chk(xword, OFS);
        chk(dword, OFS + 16'h0002);
        for (int i = 0; i < 4; i++) begin
            p = bus;
            @(negedge core_clk_in);
            chk(bus, p + 16'h0001);
        end
        // Held wait cycle keeps the latch on the current address
        p = bus;
        fetch_wait_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        chk(bus, p);
        fetch_wait_in = 1'b0;
        @(negedge core_clk_in);
        chk(bus, p + 16'h0001);
    endtask : t_reset_seq
    task automatic t_transfers();
        logic [15:0] r;
        xfer(PAG_OP_BRANCH, 16'h0000, e);
        chk(bus, e + 16'h0001 + OFS);
        chk(ptr, e + 16'h0002 + OFS);
        for (int i = 0; i < 3; i++) begin
            chk({15'h0000, exec_valid_out}, 16'h0000);
            @(negedge core_clk_in);
        end
        chk(xaddr, e + 16'h0001 + OFS);
        xfer(PAG_OP_CALL, 16'h0000, r);
        chk(top, r + 16'h0002);
        xfer(PAG_OP_RETURN, 16'h0000, e);
        chk(bus, r + 16'h0002);
        irq_num_in = 5'h05;
        xfer(PAG_OP_INTERRUPT, 16'h0000, e);
        chk(bus, 16'h000A);
        chk(top, e);
        xfer(PAG_OP_CALL_TO_ACC, 16'h1234, e);
        chk(bus, 16'h1234);
        chk(top, e + 16'h0001);
        xfer(PAG_OP_JUMP_TO_ACC, 16'h0200, e);
        chk(bus, 16'h0200);
    endtask : t_transfers
    // Nine pushes lose the first; pops past the bottom repeat it
    task automatic t_stack();
        for (int i = 0; i < 9; i++) begin
            xfer(i[0] ? PAG_OP_PUSH_DATA : PAG_OP_PUSH_ACC, 16'hA000 + 16'(i), e);
        end
        for (int k = 0; k < 9; k++) begin
            chk(top, (k < 8) ? 16'hA008 - 16'(k) : 16'hA001);
            xfer(k[0] ? PAG_OP_POP_DATA : PAG_OP_POP_ACC, 16'h0000, e);
        end
    endtask : t_stack
    task automatic t_misc();
        xfer(PAG_OP_WINDOW_WRITE, 16'h00E0, e);
        chk({8'h00, win}, 16'h00E0);
        aux_dec_we_in = 1'b1;
        aux_dec_val_in = 3'h2;
        aux_normalize_op_val_in = 3'h5;
        xfer(PAG_OP_NORMALIZE, 16'h0000, e);
        exec_op_in = PAG_OP_NONE;
        chk({13'h0000, aux}, 16'h0005);
        @(negedge core_clk_in);
        aux_dec_we_in = 1'b0;
        chk({13'h0000, aux}, 16'h0002);
        xfer(PAG_OP_REPEAT_LOAD, 16'h0002, e);
        exec_op_in = PAG_OP_NONE;
        chk(cnt, 16'h0002);
        e = xaddr;
        repeat (3) begin
            chk(xaddr, e);
            @(negedge core_clk_in);
        end
        chk(xaddr, e + 16'h0001);
    endtask : t_misc
    // Two-operand move with count one: two operand addresses, then resume
    task automatic t_move();
        logic [15:0] a;
        xfer(PAG_OP_REPEAT_LOAD, 16'h0001, e);
        xfer(PAG_OP_TWO_OPERAND, 16'h0000, a);
        exec_op_in = PAG_OP_NONE;
        chk(bus, a + 16'h0001 + OFS);
        chk(16'(st), 16'(PAG_ST_MOVE));
        @(negedge core_clk_in);
        chk(bus, a + 16'h0002 + OFS);
        @(negedge core_clk_in);
        chk(bus, a + 16'h0003);
        chk(16'(st), 16'(PAG_ST_RUN));
        @(negedge core_clk_in);
        chk(xaddr, a + 16'h0002);
    endtask : t_move
    initial begin
        {resetn_in, fetch_wait_in, aux_dec_we_in} = 3'h0;
        {data_read_path_in, irq_num_in, aux_dec_val_in, aux_normalize_op_val_in} = 27'h0;
        exec_op_in = PAG_OP_NONE;
        repeat (10) @(negedge core_clk_in);
        t_reset_seq();
        t_transfers();
        t_stack();
        t_misc();
        t_move();
        end_sim();
    end
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule : pag_gen_bench
`default_nettype wire

// *** pag_pkg.sv ***
// Shared constants and types for the program address generator
package pag_pkg;

    // ************************************************************
    // Widths and sizes
    // ************************************************************
    localparam int ADDR_W      = 16;
    localparam int STACK_DEPTH = 8;
    localparam int WIN_W       = 8;
    localparam int ARP_W       = 3;
    localparam int IRQ_W       = 5;

    // ************************************************************
    // Addresses and steps
    // ************************************************************
    localparam logic [15:0] RESET_VEC = 16'h0000;
    localparam logic [15:0] PC_STEP   = 16'h0001;
    localparam int          VEC_SH    = 1;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] COUNT_END = 16'h0000;
    localparam logic [7:0]  WIN_RESET = 8'h00;
    localparam logic [2:0]  ARP_RESET = 3'h0;

    // ************************************************************
    // Operation presented for the word in execute
    // ************************************************************
    typedef enum logic [3:0] {
        PAG_OP_NONE         = 4'h0,
        PAG_OP_BRANCH       = 4'h1,
        PAG_OP_CALL         = 4'h2,
        PAG_OP_RETURN       = 4'h3,
        PAG_OP_JUMP_TO_ACC  = 4'h4,
        PAG_OP_CALL_TO_ACC  = 4'h5,
        PAG_OP_INTERRUPT    = 4'h6,
        PAG_OP_PUSH_ACC     = 4'h7,
        PAG_OP_POP_ACC      = 4'h8,
        PAG_OP_PUSH_DATA    = 4'h9,
        PAG_OP_POP_DATA     = 4'hA,
        PAG_OP_REPEAT_LOAD  = 4'hB,
        PAG_OP_TWO_OPERAND  = 4'hC,
        PAG_OP_WINDOW_WRITE = 4'hD,
        PAG_OP_NORMALIZE    = 4'hE
    } pag_op_t;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        PAG_ST_RUN    = 3'h1,
        PAG_ST_REPEAT = 3'h2,
        PAG_ST_MOVE   = 3'h4
    } pag_state_t;

endpackage : pag_pkg

// *** pag_prog_mem.sv ***
// Program memory model answering the address bus in the same cycle
`timescale 1ns/10ps
`default_nettype none
module pag_prog_mem #(
    parameter logic [15:0] OFS = 16'h0040
) (
    input  wire logic [15:0] addr_in,
    output logic      [15:0] data_out
);
    // Word derived from address so every fetch is traceable
    assign data_out = addr_in + OFS;
endmodule : pag_prog_mem
`default_nettype wire

// *** pag_stack.sv ***
// Shift-register return stack
`timescale 1ns/10ps
`default_nettype none
module pag_stack #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             resetn_in,
    input  wire logic             push_in,
    input  wire logic             pop_in,
    input  wire logic [WIDTH-1:0] data_in,
    output logic      [WIDTH-1:0] top_out
);
    import pag_pkg::*;

    logic [WIDTH-1:0] entry [DEPTH];

    // ************************************************************
    // Storage
    // ************************************************************
    // Entries carry no reset, saving a reset net on every bit
    always_ff @(posedge core_clk_in) begin
        if (push_in) begin
            entry[0] <= data_in;
            for (int i = 1; i < DEPTH; i++) begin
                entry[i] <= entry[i-1];
            end
        end else if (pop_in) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                entry[i] <= entry[i+1];
            end
        end
    end

    assign top_out = entry[0];

    // ************************************************************
    // Checks
    // ************************************************************
    // Entries start unknown, so case equality keeps the first pushes and pops quiet
    a_push_shift: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        push_in |=> entry[0] === $past(data_in) && entry[DEPTH-1] === $past(entry[DEPTH-2]))
        else $error("push did not shift the stack");
    a_pop_bottom: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (pop_in && !push_in) |=> entry[DEPTH-1] === $past(entry[DEPTH-1])
            && entry[0] === $past(entry[1]))
        else $error("pop did not shift up or lost bottom");

endmodule : pag_stack
`default_nettype wire
